// [touch_out_pkg.sv]
// Shared constants and types for the touch output mode controller
package touch_out_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// Timing figures in their own units
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned HOLD_SHORT_S = 10;
	localparam int unsigned HOLD_LONG_S = 60;
	localparam int unsigned LIVENESS_US = 300;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned HOLD_SHORT_TICKS = HOLD_SHORT_S * 1000 / TICK_MS;
	localparam int unsigned HOLD_LONG_TICKS = HOLD_LONG_S * 1000 / TICK_MS;
	localparam int unsigned LIVENESS_CYCLES = CLK_HZ / 1_000_000 * LIVENESS_US;
	localparam int unsigned CONSENSUS = 3;
	localparam int unsigned TICK_W = 17;
	localparam int unsigned HOLD_W = 16;
	localparam int unsigned HB_W = 15;
	// Register byte offsets and fields
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int unsigned CTRL_RECAL_BIT = 0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {HOLD_SHORT, HOLD_LONG, HOLD_NONE} hold_t;

	typedef struct packed {
		logic toggle;
		hold_t hold;
	} mode_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] straps;
		logic valid;
		logic [1:0] fill;
	} strap_state_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic detect;
		logic [1:0] cons;
		logic blocked;
		logic toggle_on;
		logic pin_high;
		logic oe;
		logic recal;
		logic [TICK_W-1:0] tick;
		logic [HOLD_W-1:0] hold;
		logic [HB_W-1:0] hb;
		logic hb_act;
	} ctl_state_t;

	// Strap a is the first strap, b the second
	function automatic mode_t decode_straps(input logic a, input logic b);
		mode_t m;
		m.toggle = 1'b0;
		m.hold = HOLD_SHORT;
		if (a && !b) begin
			m.hold = HOLD_LONG;
		end else if (!a && b) begin
			m.hold = HOLD_NONE;
		end else if (!a && !b) begin
			m.toggle = 1'b1;
		end
		return m;
	endfunction
endpackage

// [strap_sampler.sv]
// Power-up capture of the two option straps
`timescale 1ns/10ps
`default_nettype none
module strap_sampler (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [1:0] pins_in,
	output logic [1:0] straps_out,
	output logic valid_out
);
	touch_out_pkg::strap_state_t s, next_s;

	always_comb begin
		next_s = s;
		next_s.s1 = pins_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// Stages hold reset zeros at first, so wait until all three are real
		next_s.fill = (s.fill == 2'h3) ? s.fill : s.fill + 2'h1;
		// Captured once; later strap changes are ignored until reset
		if (!s.valid && s.fill == 2'h3 && s.s2 == s.s3) begin
			next_s.straps = s.s3;
			next_s.valid = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign straps_out = s.straps;
	assign valid_out = s.valid;
endmodule
`default_nettype wire

// [touch_output_mode_control.sv]
// Output stage of a single-channel touch sensor with AHB-Lite status access
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module touch_output_mode_control #(
	parameter int unsigned TICK_CYCLES = touch_out_pkg::TICK_CYCLES,
	parameter int unsigned HOLD_SHORT_TICKS = touch_out_pkg::HOLD_SHORT_TICKS,
	parameter int unsigned HOLD_LONG_TICKS = touch_out_pkg::HOLD_LONG_TICKS,
	parameter int unsigned LIVENESS_CYCLES = touch_out_pkg::LIVENESS_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic option_strap_a_in,
	input wire logic option_strap_b_in,
	input wire logic burst_done_in,
	input wire logic burst_detect_in,
	output logic sense_out,
	output logic sense_oe_out,
	output logic recal_out,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out
);
	localparam logic [1:0] CONS_LAST = 2'(touch_out_pkg::CONSENSUS - 1);
	localparam int unsigned TICK_W_L = touch_out_pkg::TICK_W;
	localparam logic [TICK_W_L-1:0] TICK_LAST = TICK_W_L'(TICK_CYCLES - 1);
	localparam int unsigned HOLD_W_L = touch_out_pkg::HOLD_W;
	localparam int unsigned HB_W_L = touch_out_pkg::HB_W;
	localparam logic [HOLD_W_L-1:0] SHORT_LIM = HOLD_W_L'(HOLD_SHORT_TICKS);
	localparam logic [HOLD_W_L-1:0] LONG_LIM = HOLD_W_L'(HOLD_LONG_TICKS);
	localparam logic [HB_W_L-1:0] HB_LAST = HB_W_L'(LIVENESS_CYCLES - 1);

	touch_out_pkg::ctl_state_t s, next_s;
	touch_out_pkg::mode_t mode;
	logic [1:0] straps;
	logic straps_valid;
	logic tick;
	logic expire;
	logic sw_recal;
	logic burst;
	logic [HOLD_W_L-1:0] limit;
	logic [31:0] rd_value;
	logic take;
	logic [HB_W_L-1:0] float_len;

	////////////////////////////////////////////////////////////////////////
	// power-up strap capture
	strap_sampler u_straps (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.pins_in({option_strap_a_in, option_strap_b_in}),
		.straps_out(straps),
		.valid_out(straps_valid)
	);

	assign mode = touch_out_pkg::decode_straps(straps[1], straps[0]);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.recal = 1'b0;
		// Only whole-word transfers inside the block's window are taken
		take = hready_in && hsel_in && htrans_in[1] && hsize_in == 3'h2
			&& haddr_in[31:8] == 24'h000000;
		rd_value = 32'h0000_0000;
		if ({haddr_in[7:2], 2'b00} == touch_out_pkg::STATUS_OFS) begin
			rd_value = {21'h000000, straps_valid, s.hb_act, s.cons,
				s.toggle_on, s.detect, mode.hold, mode.toggle,
				s.blocked, !s.pin_high};
		end
		// Write takes effect at the end of its data phase
		sw_recal = s.wr_pend && s.waddr == touch_out_pkg::CTRL_OFS
			&& hwdata_in[touch_out_pkg::CTRL_RECAL_BIT];
		// Read data must stand in the data phase, so fetch it now
		next_s.wr_pend = 1'b0;
		next_s.hrdata = 32'h0000_0000;
		if (take) begin
			next_s.wr_pend = hwrite_in;
			next_s.waddr = {haddr_in[7:2], 2'b00};
			if (!hwrite_in) begin
				next_s.hrdata = rd_value;
			end
		end
		tick = s.tick == TICK_LAST;
		next_s.tick = tick ? '0 : s.tick + 1'b1;
		// toggle mode forces the short timeout
		limit = (mode.toggle || mode.hold == touch_out_pkg::HOLD_SHORT)
			? SHORT_LIM : LONG_LIM;
		expire = s.detect && s.hold == limit
			&& (mode.toggle || mode.hold != touch_out_pkg::HOLD_NONE);
		burst = burst_done_in && straps_valid;
		if (burst) begin
			if (!burst_detect_in) begin
				next_s.cons = 2'b00;
				next_s.detect = 1'b0;
				next_s.blocked = 1'b0;
			end else if (!s.blocked && !s.detect) begin
				if (s.cons == CONS_LAST) begin
					next_s.detect = 1'b1;
				end else begin
					next_s.cons = s.cons + 1'b1;
				end
			end
		end
		if (!s.detect) begin
			next_s.hold = '0;
		end else if (tick) begin
			next_s.hold = s.hold + 1'b1;
		end
		// recalibration clears detection until a clean burst
		if (expire || sw_recal) begin
			next_s.recal = 1'b1;
			next_s.detect = 1'b0;
			next_s.cons = 2'b00;
			next_s.hold = '0;
			next_s.blocked = 1'b1;
		end
		if (mode.toggle && next_s.detect && !s.detect) begin
			next_s.toggle_on = !s.toggle_on;
		end
		if (s.hb_act) begin
			next_s.hb = s.hb + 1'b1;
			if (s.hb == HB_LAST) begin
				next_s.hb_act = 1'b0;
			end
		end
		if (burst) begin
			next_s.hb_act = 1'b1;
			next_s.hb = '0;
		end
		// detection keeps the pin driven, with no liveness float
		if (next_s.detect) begin
			next_s.hb_act = 1'b0;
		end
		next_s.pin_high = mode.toggle ? !next_s.toggle_on : !next_s.detect;
		next_s.oe = !next_s.hb_act;
		if (!straps_valid) begin
			next_s.pin_high = 1'b1;
		end
	end

	// output inactive and toggle off out of reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s <= '0;
			s.pin_high <= 1'b1;
			s.oe <= 1'b1;
			s.hrdata <= touch_out_pkg::RDATA_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign sense_out = s.pin_high;
	assign sense_oe_out = s.oe;
	assign recal_out = s.recal;
	assign hrdata_out = s.hrdata;
	// Zero wait states, always OKAY
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;

	// Assertion helper: float cycles since the float began or was restarted
	always_ff @(posedge clk_in) begin
		if (srst_in || sense_oe_out || burst) begin
			float_len <= '0;
		end else begin
			float_len <= float_len + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence clean_burst_s;
		burst_done_in && straps_valid && !burst_detect_in;
	endsequence

	level_follows_a: assert property (
		!mode.toggle && straps_valid |-> sense_out == !s.detect
	) else $error("level output not following detection");
	detect_consensus_a: assert property (
		$rose(s.detect) |-> $past(burst_done_in && burst_detect_in)
			&& $past(s.cons) == CONS_LAST
	) else $error("detection without three bursts");
	miss_clears_a: assert property (
		clean_burst_s |=> s.cons == 2'b00 && !s.detect
	) else $error("missed burst kept the count");
	toggle_flip_a: assert property (
		mode.toggle && $rose(s.detect) |-> s.toggle_on != $past(s.toggle_on)
	) else $error("toggle state did not flip");
	recal_keeps_a: assert property (
		mode.toggle && s.recal |-> s.toggle_on == $past(s.toggle_on)
	) else $error("recalibration changed toggle state");
	timeout_recal_a: assert property (
		expire |=> s.recal && !s.detect
	) else $error("timeout without recalibration");
	no_inf_timeout_a: assert property (
		!mode.toggle && mode.hold == touch_out_pkg::HOLD_NONE
			|-> !s.recal || $past(sw_recal)
	) else $error("infinite hold expired");
	float_length_a: assert property (
		$rose(sense_oe_out) && !s.detect
			|-> float_len == HB_W_L'(LIVENESS_CYCLES)
	) else $error("liveness float too short");
	no_float_detect_a: assert property (
		s.detect |-> sense_oe_out
	) else $error("float during detection");
	start_idle_a: assert property (
		!straps_valid |-> sense_out && !s.toggle_on
	) else $error("output active before start");
endmodule
`default_nettype wire

// [touch_load_model.sv]
// Load model on the sense pin: switchable resistor and pulse counter
`timescale 1ns/10ps
`default_nettype none
module touch_load_model (
	input wire logic clk_in,
	input wire logic sense_in,
	input wire logic oe_in,
	input wire logic pull_up_in,
	output logic line_out,
	output int pulses_out
);
	logic line_q = 1'b0;
	int count = 0;
	assign line_out = oe_in ? sense_in : pull_up_in;
	assign pulses_out = count;
	// count float pulses
	// A float that matches the driven level is invisible, so it is not counted
	always @(posedge clk_in) begin
		line_q <= line_out;
		if (!oe_in && line_q !== line_out) begin
			count <= count + 1;
		end
	end
endmodule
`default_nettype wire

// [test_touch_output_mode_control.sv]
// Self-checking bench for the touch output mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_touch_output_mode_control;
	logic clk_in = 1'b0, srst_in = 1'b1, sa = 1'b1, sb = 1'b1;
	logic bdone = 1'b0, bdet = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic pull_up = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic sense, oe, recal, hready, hresp, line;
	logic [1:0] st[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	logic [31:0] ex[4] = '{32'h400, 32'h408, 32'h404, 32'h410};
	int failures = 0, checked = 0, cycles = 0, recals = 0, p0, r0;
	int pulses;
	touch_output_mode_control #(.TICK_CYCLES(10), .HOLD_SHORT_TICKS(5),
		.HOLD_LONG_TICKS(8), .LIVENESS_CYCLES(20)) dut (.clk_in(clk_in),
		.srst_in(srst_in), .option_strap_a_in(sa), .option_strap_b_in(sb),
		.burst_done_in(bdone), .burst_detect_in(bdet), .sense_out(sense),
		.sense_oe_out(oe), .recal_out(recal), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));
	touch_load_model load (.clk_in(clk_in), .sense_in(sense), .oe_in(oe),
		.pull_up_in(pull_up), .line_out(line), .pulses_out(pulses));
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (recal === 1'b1) recals++;
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task burst(input logic d, input int gap);
		@(posedge clk_in);
		bdone <= 1'b1;
		bdet <= d;
		@(posedge clk_in);
		bdone <= 1'b0;
		tick(gap);
	endtask
	task det;
		repeat (3) burst(1'b1, 3);
	endtask
	// Zero-wait slave, but the master still waits on hready each phase
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task setup(input logic a, input logic b);
		@(posedge clk_in);
		sa <= a;
		sb <= b;
		srst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		tick(8);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 4; i++) begin
			setup(st[i][1], st[i][0]);
			`CHK(sense, 1'b1)
			ahb(1'b0, 32'h4, 32'h0);
			`CHK(rd & 32'h41c, ex[i])
			@(posedge clk_in);
			sa <= ~sa;
			sb <= ~sb;
			tick(10);
			ahb(1'b0, 32'h4, 32'h0);
			`CHK(rd & 32'h41c, ex[i])
		end
		setup(1'b1, 1'b1);
		r0 = recals;
		ahb(1'b1, 32'h0, 32'h1);
		tick(3);
		`CHK(recals, r0 + 1)
		ahb(1'b0, 32'h8, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(hresp, 1'b0)
		p0 = pulses;
		burst(1'b0, 2);
		`CHK(oe, 1'b0)
		tick(22);
		`CHK(oe, 1'b1)
		`CHK(pulses, p0 + 1)
		det();
		`CHK(sense, 1'b0)
		p0 = pulses;
		r0 = recals;
		burst(1'b1, 22);
		`CHK(pulses, p0)
		`CHK(sense, 1'b0)
		tick(45);
		`CHK(recals, r0 + 1)
		`CHK(sense, 1'b1)
		burst(1'b1, 3);
		`CHK(sense, 1'b1)
		burst(1'b0, 25);
		burst(1'b1, 3);
		burst(1'b1, 3);
		burst(1'b0, 3);
		burst(1'b1, 3);
		burst(1'b1, 3);
		`CHK(sense, 1'b1)
		burst(1'b1, 3);
		`CHK(sense, 1'b0)
		burst(1'b0, 3);
		`CHK(sense, 1'b1)
		setup(1'b0, 1'b1);
		det();
		r0 = recals;
		tick(150);
		`CHK(sense, 1'b0)
		`CHK(recals, r0)
		setup(1'b1, 1'b0);
		det();
		r0 = recals;
		tick(55);
		`CHK(sense, 1'b0)
		tick(45);
		`CHK(recals, r0 + 1)
		`CHK(sense, 1'b1)
		setup(1'b0, 1'b0);
		det();
		`CHK(sense, 1'b0)
		r0 = recals;
		tick(60);
		`CHK(recals, r0 + 1)
		`CHK(sense, 1'b0)
		p0 = pulses;
		@(posedge clk_in);
		pull_up <= 1'b1;
		burst(1'b0, 25);
		`CHK(pulses, p0 + 1)
		`CHK(sense, 1'b0)
		@(posedge clk_in);
		pull_up <= 1'b0;
		det();
		`CHK(sense, 1'b1)
		summarize();
	end
endmodule
`default_nettype wire
